//--- core/rsdc_pkg.sv
package rsdc_pkg;
    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] SWITCH_CFG_ADDR = 8'hbe;
    localparam logic [7:0] SS_TSSC_ADDR = 8'hac;
    localparam logic [7:0] SS_NSSC_ADDR = 8'had;
    localparam logic [7:0] SS_OFFSET_ADDR = 8'hae;
    localparam logic [7:0] FRACTIONAL_LOOP_D_ADDR = 8'hc4;
    localparam logic [7:0] FRACTIONAL_LOOP_N_ADDR = 8'hc5;
    localparam logic [7:0] FRACTIONAL_LOOP_A_ADDR = 8'hc6;
    localparam logic [7:0] ODIV_BASE_ADDR = 8'hd0;
    localparam logic [7:0] STATUS_ADDR = 8'he0;
    localparam logic [7:0] MTOTAL_ADDR = 8'he1;
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int PRIM_BIT = 0;
    localparam int SM_LSB = 1;
    localparam int PM_BIT = 7;
    localparam logic [6:0] Q_ALL_ONES = 7'h7f;
    localparam logic [7:0] ODIV_RESET = 8'h7f;
    localparam logic [1:0] OEM_RESET = 2'h0;
    localparam int NUM_ODIV = 6;
    localparam logic [1:0] LOSS_CYCLES = 2'h2;
    localparam logic [1:0] OEM_LOW = 2'h0;
    localparam logic [1:0] OEM_HIGH = 2'h1;
endpackage : rsdc_pkg

//--- core/rsdc_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Primary-source bit 0 picks crystal/ref input, 1 picks aux clock
// - Switch-mode upper bit clear: input-select pin chooses primary or secondary
// - Manual switchover produces no output glitches
// - Automatic: move to secondary after two secondary cycles without primary edges
// - Automatic switchover is revertive to the primary when present
// - Switchover waits until both references are low; no short pulses
// - Each loop: 7-bit reference divider and 12-bit feedback count
// - Fractional loop feedback is 2N+A+1 when A nonzero, else 2N
// - Undivided output has no divider; six outputs have 8-bit post-dividers
// - All-ones count: mode0 off, mode1 /1; else mode0 /2, mode1 /(2Q+4)
// - Disabled divider emits no clock; pin state follows disabled-output-state
// - Spread enabled whenever step-period field is nonzero
// - Samples-per-quadrant sets quadrant length; four mirrored quadrants (no spread generator here: nssc_r is only stored and read back)
// - Center-shift zero gives center spread, nonzero gives down spread
// - Spread parameters live at 0xac through 0xbd
// - Switch mode and primary bit live at 0xbe through 0xc3
// - Post-dividers bypass or divide by even integers 2 to 256
module rsdc_ctrl #(
    parameter int NDIV = 6
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // References and selection
    input wire logic crystal_ref_input_in,
    input wire logic aux_clock_input_in,
    input wire logic input_select_pin_in,
    output logic sel_aux_out,
    output logic ref_clk_out,
    // Clock outputs
    input wire logic [3:0] bank_clk_in,
    output logic undivided_output_out,
    output logic [NDIV-1:0] div_clk_out,
    output logic [NDIV-1:0] div_oe_out,
    // Derived loop and spread settings
    output logic [13:0] m_total_out,
    output logic [6:0] ref_div_out,
    output logic ss_enable_out,
    output logic ss_down_out
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [13:0] rsdc_mtot(input logic [11:0] n, input logic [3:0] a);
        logic [13:0] m;
        m = {1'b0, n, 1'b0};
        if (a != 4'h0) begin
            m = m + {10'h000, a} + 14'h0001;
        end
        return m;
    endfunction : rsdc_mtot

    // Divider decode: 0 off, 1 bypass, else half-period count plus one
    function automatic logic [8:0] rsdc_half(input logic [7:0] r);
        logic [8:0] h;
        h = 9'h000;
        if (r[6:0] == rsdc_pkg::Q_ALL_ONES) begin
            h = r[rsdc_pkg::PM_BIT] ? 9'h001 : 9'h000;
        end else if (!r[rsdc_pkg::PM_BIT]) begin
            h = 9'h002;
        end else begin
            h = {2'h0, r[6:0]} + 9'h003;
        end
        return h;
    endfunction : rsdc_half

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [2:0] sw_r, sw_nxt;
    logic [3:0] tssc_r, tssc_nxt;
    logic [2:0] nssc_r, nssc_nxt;
    logic [5:0] ofs_r, ofs_nxt;
    logic [6:0] d_r, d_nxt;
    logic [11:0] n_r, n_nxt;
    logic [3:0] a_r, a_nxt;
    logic [1:0] oem_r, oem_nxt;
    logic [7:0] odiv_r [NDIV], odiv_nxt [NDIV];
    logic [7:0] rdata_r, rdata_nxt;

    always_comb begin
        sw_nxt = sw_r;
        tssc_nxt = tssc_r;
        nssc_nxt = nssc_r;
        ofs_nxt = ofs_r;
        d_nxt = d_r;
        n_nxt = n_r;
        a_nxt = a_r;
        oem_nxt = oem_r;
        odiv_nxt = odiv_r;
        rdata_nxt = 8'h00;
        if (wr_in) begin
            unique case (addr_in)
                rsdc_pkg::SWITCH_CFG_ADDR: begin
                    sw_nxt = wdata_in[2:0];
                    oem_nxt = wdata_in[5:4];
                end
                rsdc_pkg::SS_TSSC_ADDR: tssc_nxt = wdata_in[3:0];
                rsdc_pkg::SS_NSSC_ADDR: nssc_nxt = wdata_in[2:0];
                rsdc_pkg::SS_OFFSET_ADDR: ofs_nxt = wdata_in[5:0];
                rsdc_pkg::FRACTIONAL_LOOP_D_ADDR: d_nxt = wdata_in[6:0];
                rsdc_pkg::FRACTIONAL_LOOP_N_ADDR: n_nxt = {wdata_in[3:0], n_r[7:0]};
                rsdc_pkg::FRACTIONAL_LOOP_A_ADDR: a_nxt = wdata_in[3:0];
                default: begin
                    for (int i = 0; i < NDIV; i++) begin
                        if (addr_in == rsdc_pkg::ODIV_BASE_ADDR + 8'(i)) begin
                            odiv_nxt[i] = wdata_in;
                        end
                    end
                    if (addr_in == rsdc_pkg::FRACTIONAL_LOOP_N_ADDR + 8'h08) begin
                        n_nxt = {n_r[11:8], wdata_in};
                    end
                end
            endcase
        end
        if (rd_in) begin
            unique case (addr_in)
                rsdc_pkg::SWITCH_CFG_ADDR: rdata_nxt = {2'h0, oem_r, 1'b0, sw_r};
                rsdc_pkg::SS_TSSC_ADDR: rdata_nxt = {4'h0, tssc_r};
                rsdc_pkg::SS_NSSC_ADDR: rdata_nxt = {5'h00, nssc_r};
                rsdc_pkg::SS_OFFSET_ADDR: rdata_nxt = {2'h0, ofs_r};
                rsdc_pkg::FRACTIONAL_LOOP_D_ADDR: rdata_nxt = {1'b0, d_r};
                rsdc_pkg::FRACTIONAL_LOOP_N_ADDR: rdata_nxt = {4'h0, n_r[11:8]};
                rsdc_pkg::FRACTIONAL_LOOP_A_ADDR: rdata_nxt = {4'h0, a_r};
                rsdc_pkg::STATUS_ADDR: rdata_nxt = {6'h00, ss_enable_out, sel_aux_out};
                rsdc_pkg::MTOTAL_ADDR: rdata_nxt = m_total_out[7:0];
                default: begin
                    for (int i = 0; i < NDIV; i++) begin
                        if (addr_in == rsdc_pkg::ODIV_BASE_ADDR + 8'(i)) begin
                            rdata_nxt = odiv_r[i];
                        end
                    end
                    if (addr_in == rsdc_pkg::FRACTIONAL_LOOP_N_ADDR + 8'h08) begin
                        rdata_nxt = n_r[7:0];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sw_r <= 3'h0;
            tssc_r <= 4'h0;
            nssc_r <= 3'h0;
            ofs_r <= 6'h00;
            d_r <= 7'h01;
            n_r <= 12'h000;
            a_r <= 4'h0;
            oem_r <= rsdc_pkg::OEM_RESET;
            rdata_r <= 8'h00;
            for (int i = 0; i < NDIV; i++) begin
                odiv_r[i] <= rsdc_pkg::ODIV_RESET;
            end
        end else begin
            sw_r <= sw_nxt;
            tssc_r <= tssc_nxt;
            nssc_r <= nssc_nxt;
            ofs_r <= ofs_nxt;
            d_r <= d_nxt;
            n_r <= n_nxt;
            a_r <= a_nxt;
            oem_r <= oem_nxt;
            rdata_r <= rdata_nxt;
            odiv_r <= odiv_nxt;
        end
    end
    assign rdata_out = rdata_r;
    assign m_total_out = rsdc_mtot(n_r, a_r);
    assign ref_div_out = d_r;
    assign ss_enable_out = (tssc_r != 4'h0);
    assign ss_down_out = (ofs_r != 6'h00);

    // ------------------------------------------------------------
    // Reference selection
    // ------------------------------------------------------------
    // References are sampled as ordinary inputs; waiting until both are low
    // is what keeps the switch from cutting a half period short.
    logic prim_d_r, prim_d_nxt, sec_d_r, sec_d_nxt;
    logic [1:0] loss_r, loss_nxt;
    logic sel_r, sel_nxt;
    logic prim_in, sec_in;

    always_comb begin
        prim_in = sw_r[rsdc_pkg::PRIM_BIT] ? aux_clock_input_in : crystal_ref_input_in;
        sec_in = sw_r[rsdc_pkg::PRIM_BIT] ? crystal_ref_input_in : aux_clock_input_in;
        prim_d_nxt = prim_in;
        sec_d_nxt = sec_in;
        loss_nxt = loss_r;
        if (prim_in != prim_d_r) begin
            loss_nxt = 2'h0;
        end else if (sec_in && !sec_d_r && loss_r != rsdc_pkg::LOSS_CYCLES) begin
            loss_nxt = loss_r + 2'h1;
        end
        if (!sw_r[rsdc_pkg::SM_LSB+1]) begin
            sel_nxt = input_select_pin_in;
        end else begin
            sel_nxt = (loss_nxt == rsdc_pkg::LOSS_CYCLES);
        end
    end

    logic ref_r, ref_nxt, sel_upd;
    always_comb begin
        ref_nxt = ref_r;
        sel_upd = sel_r;
        // Change source only while both are low: no runt pulse
        if (sel_r == sel_nxt || (!prim_in && !sec_in)) begin
            sel_upd = sel_nxt;
            ref_nxt = sel_r ? sec_in : prim_in;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prim_d_r <= 1'b0;
            sec_d_r <= 1'b0;
            loss_r <= 2'h0;
            sel_r <= 1'b0;
            ref_r <= 1'b0;
        end else begin
            prim_d_r <= prim_d_nxt;
            sec_d_r <= sec_d_nxt;
            loss_r <= loss_nxt;
            sel_r <= sel_upd;
            ref_r <= ref_nxt;
        end
    end
    assign sel_aux_out = sel_r ^ sw_r[rsdc_pkg::PRIM_BIT];
    assign ref_clk_out = ref_r;

    // ------------------------------------------------------------
    // Output dividers
    // ------------------------------------------------------------
    logic [8:0] cnt_r [NDIV], cnt_nxt [NDIV];
    logic [NDIV-1:0] ph_r, ph_nxt, bk_d_r, bk_d_nxt;
    logic [NDIV-1:0] out_nxt, oe_nxt, out_r, oe_r;
    logic und_r;

    always_comb begin
        for (int i = 0; i < NDIV; i++) begin
            logic [8:0] h;
            logic b;
            h = rsdc_half(odiv_r[i]);
            b = bank_clk_in[i % 4];
            bk_d_nxt[i] = b;
            cnt_nxt[i] = cnt_r[i];
            ph_nxt[i] = ph_r[i];
            if (b && !bk_d_r[i] && h > 9'h001) begin
                if (cnt_r[i] + 9'h002 >= h) begin
                    cnt_nxt[i] = 9'h000;
                    ph_nxt[i] = !ph_r[i];
                end else begin
                    cnt_nxt[i] = cnt_r[i] + 9'h001;
                end
            end
            oe_nxt[i] = 1'b1;
            if (h == 9'h000) begin
                // Disabled: no clock, powered unless field is 2, level from control field
                oe_nxt[i] = (oem_r != 2'h2);
                out_nxt[i] = (oem_r == rsdc_pkg::OEM_HIGH);
            end else if (h == 9'h001) begin
                out_nxt[i] = b;
            end else begin
                out_nxt[i] = ph_r[i];
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ph_r <= '0;
            bk_d_r <= '0;
            out_r <= '0;
            oe_r <= '0;
            und_r <= 1'b0;
            for (int i = 0; i < NDIV; i++) begin
                cnt_r[i] <= 9'h000;
            end
        end else begin
            ph_r <= ph_nxt;
            bk_d_r <= bk_d_nxt;
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            und_r <= bank_clk_in[0];
            cnt_r <= cnt_nxt;
        end
    end
    assign div_clk_out = out_r;
    assign div_oe_out = oe_r;
    assign undivided_output_out = und_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_SS_EN: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (wr_in && addr_in == rsdc_pkg::SS_TSSC_ADDR) |=> (ss_enable_out == ($past(wdata_in[3:0]) != 4'h0)))
        else $error("spread enable wrong");
    AST_MTOT: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (a_r == 4'h0) |-> (m_total_out == {1'b0, n_r, 1'b0}))
        else $error("feedback total wrong");
    AST_MANUAL: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (!sw_r[2] && !prim_in && !sec_in) |=> (sel_r == $past(input_select_pin_in)))
        else $error("manual select not followed");
    AST_REVERT: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (sw_r[2] && prim_in != prim_d_r) |=> (loss_r == 2'h0))
        else $error("loss count not cleared");
    AST_LOSS: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ($past(sw_r[2]) && $rose(sel_r)) |-> (loss_r == rsdc_pkg::LOSS_CYCLES))
        else $error("switched before loss detected");
    AST_DISABLED: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (odiv_r[0] == 8'h7f && oem_r == rsdc_pkg::OEM_LOW) |=> (!div_clk_out[0] && div_oe_out[0]))
        else $error("disabled output drives clock");
    AST_RDATA: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (rd_in && addr_in == rsdc_pkg::SWITCH_CFG_ADDR) |=> (rdata_out[2:0] == sw_r))
        else $error("switch config readback wrong");
    AST_DOWN: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (wr_in && addr_in == rsdc_pkg::SS_OFFSET_ADDR) |=> (ss_down_out == ($past(wdata_in[5:0]) != 6'h00)))
        else $error("down spread flag wrong");
    COV_AUTO: cover property (@(posedge clk_in) disable iff (!nrst_in) sw_r[2] ##1 sel_r);
    COV_MAN: cover property (@(posedge clk_in) disable iff (!nrst_in) !sw_r[2] && $rose(sel_r));
    COV_SS: cover property (@(posedge clk_in) disable iff (!nrst_in) $rose(ss_enable_out));
endmodule : rsdc_ctrl
`default_nettype wire

//--- verification/rsdc_ref_model.sv
`timescale 1ns/100ps
`default_nettype none
module rsdc_ref_model (
    // Clock
    input wire logic clk_in,
    // Source control
    input wire logic xtal_run_in,
    input wire logic aux_run_in,
    // Reference levels
    output logic crystal_ref_input_out,
    output logic aux_clock_input_out
);
    logic [1:0] xcnt_r;
    logic [1:0] acnt_r;
    initial begin
        crystal_ref_input_out = 1'b0;
        aux_clock_input_out = 1'b0;
        xcnt_r = 2'h0;
        acnt_r = 2'h0;
    end
    // ------------------------------------------------------------
    // Sources: aux is the slower one, stopped sources fall low
    // ------------------------------------------------------------
    always @(posedge clk_in) begin
        if (!xtal_run_in) begin
            crystal_ref_input_out <= 1'b0;
            xcnt_r <= 2'h0;
        end else if (xcnt_r == 2'h1) begin
            crystal_ref_input_out <= ~crystal_ref_input_out;
            xcnt_r <= 2'h0;
        end else begin
            xcnt_r <= xcnt_r + 2'h1;
        end
        if (!aux_run_in) begin
            aux_clock_input_out <= 1'b0; // Pulled down when idle
            acnt_r <= 2'h0;
        end else if (acnt_r == 2'h2) begin
            aux_clock_input_out <= ~aux_clock_input_out;
            acnt_r <= 2'h0;
        end else begin
            acnt_r <= acnt_r + 2'h1;
        end
    end
endmodule : rsdc_ref_model
`default_nettype wire

//--- verification/rsdc_ctrl_bench.sv
`timescale 1ns/100ps
`default_nettype none
module rsdc_ctrl_bench;
    typedef struct {logic [11:0] n; logic [3:0] a; logic [13:0] m; logic [7:0] pq; int edges;} rsdc_row_t;
    logic clk_in, nrst_in, wr_in, rd_in, pin, xtal_run, aux_run, xref, aux;
    logic sel_aux, ref_clk, undiv, ss_en, ss_down, cnt_en, gl_chk, dprev, uprev, rprev;
    logic [7:0] addr_in, wdata_in, rdata_out, d;
    logic [3:0] bank;
    logic [1:0] bcnt;
    logic [5:0] dclk, doe;
    logic [13:0] m_total;
    logic [6:0] ref_div;
    int error_cnt, comparisons, n_div, n_und, hi_len, n_ref;
    logic [7:0] stp [3] = '{8'h00, 8'h05, 8'h0e};
    logic [7:0] ofv [3] = '{8'h00, 8'h01, 8'h3f};
    // Windows of 256 bank periods; near-integer results allow one edge of slack
    rsdc_row_t rows [7] = '{'{12'd22, 4'd0, 14'd44, 8'h80, 64}, '{12'd22, 4'd3, 14'd48, 8'h81, 43},
        '{12'd4095, 4'd0, 14'd8190, 8'h84, 21}, '{12'd100, 4'd15, 14'd216, 8'hff, 256},
        '{12'd1, 4'd1, 14'd4, 8'h00, 128}, '{12'd4095, 4'd15, 14'd8206, 8'hfe, 1},
        '{12'd0, 4'd0, 14'd0, 8'h7f, 0}};
    rsdc_ctrl DUT (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .crystal_ref_input_in(xref), .aux_clock_input_in(aux),
        .input_select_pin_in(pin), .sel_aux_out(sel_aux), .ref_clk_out(ref_clk), .bank_clk_in(bank),
        .undivided_output_out(undiv), .div_clk_out(dclk), .div_oe_out(doe), .m_total_out(m_total),
        .ref_div_out(ref_div), .ss_enable_out(ss_en), .ss_down_out(ss_down));
    rsdc_ref_model refs (.clk_in(clk_in), .xtal_run_in(xtal_run), .aux_run_in(aux_run),
        .crystal_ref_input_out(xref), .aux_clock_input_out(aux));
    // ------------------------------------------------------------
    // Clock, bank clocks, edge counters, pulse-width monitor
    // ------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        bcnt <= bcnt + 2'h1;
        if (bcnt[0]) bank <= ~bank;
        dprev <= dclk[0];
        uprev <= undiv;
        rprev <= ref_clk;
        if (cnt_en && ref_clk && !rprev) n_ref++;
        if (cnt_en && dclk[0] && !dprev) n_div++;
        if (cnt_en && undiv && !uprev) n_und++;
        if (ref_clk) hi_len++;
        else begin
            if (gl_chk && hi_len == 1) fail("short reference pulse");
            hi_len = 0;
        end
    end
    task automatic fail(input string msg);
        error_cnt++;
        $display("ERROR %0t %s", $time, msg);
    endtask : fail
    task automatic cmp_v(input logic [13:0] got, input logic [13:0] exp, input string what);
        comparisons++;
        if (got !== exp) fail(what);
    endtask : cmp_v
    task automatic cmp_n(input int got, input int exp);
        comparisons++;
        if (got < exp - 1 || got > exp + 1) fail("edge count");
    endtask : cmp_n
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= v;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 v = rdata_out;
    endtask : rd_reg
    task automatic wait_sel(input logic exp);
        for (int i = 0; i < 40 && sel_aux !== exp; i++) @(negedge clk_in);
        #1;
    endtask : wait_sel
    task automatic close_out;
        if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    initial begin
        repeat (30000) @(posedge clk_in);
        fail("timeout");
        close_out();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {nrst_in, wr_in, rd_in, pin, cnt_en, gl_chk, dprev, uprev, rprev} = 9'h000;
        {xtal_run, aux_run} = 2'h3;
        {addr_in, wdata_in, bank, bcnt} = 22'h0;
        {error_cnt, comparisons, n_div, n_und, hi_len, n_ref} = 192'h0;
        repeat (2) @(posedge clk_in);
        #1 cmp_v(14'(doe), 14'h0, "oe in reset");
        cmp_v(14'(sel_aux), 14'h0, "sel in reset");
        @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        #1 cmp_v(14'(ref_div), 14'h1, "ref div reset");
        cmp_v(14'(dclk), 14'h0, "disabled low");
        cmp_v(14'(doe), 14'h3f, "disabled powered");
        foreach (rows[i]) begin
            wr_reg(rsdc_pkg::FRACTIONAL_LOOP_N_ADDR, {4'h0, rows[i].n[11:8]});
            wr_reg(8'hcd, rows[i].n[7:0]);
            wr_reg(rsdc_pkg::FRACTIONAL_LOOP_A_ADDR, {4'h0, rows[i].a});
            wr_reg(rsdc_pkg::ODIV_BASE_ADDR, rows[i].pq);
            @(posedge clk_in);
            #1 cmp_v(m_total, rows[i].m, "feedback total");
            rd_reg(rsdc_pkg::MTOTAL_ADDR, d);
            cmp_v(14'(d), 14'(rows[i].m[7:0]), "feedback readback");
            n_div = 0;
            n_und = 0;
            cnt_en = 1'b1;
            repeat (1024) @(posedge clk_in);
            #1 cnt_en = 1'b0;
            cmp_n(n_div, rows[i].edges);
            cmp_n(n_und, 256);
        end
        for (int s = 0; s < 3; s++) begin
            wr_reg(rsdc_pkg::SWITCH_CFG_ADDR, {2'h0, 2'(s), 4'h0});
            repeat (4) @(posedge clk_in);
            #1 cmp_v(14'(dclk[0]), 14'(s == 1), "disabled level");
            cmp_v(14'(doe[0]), 14'(s != 2), "disabled enable");
        end
        wr_reg(rsdc_pkg::SWITCH_CFG_ADDR, 8'h23);
        wr_reg(8'hf0, 8'h55);
        rd_reg(rsdc_pkg::SWITCH_CFG_ADDR, d);
        cmp_v(14'(d), 14'h23, "switch cfg readback");
        rd_reg(8'hff, d);
        cmp_v(14'(d), 14'h0, "unmapped read");
        foreach (stp[k]) begin
            wr_reg(rsdc_pkg::SS_TSSC_ADDR, stp[k]);
            rd_reg(rsdc_pkg::SS_TSSC_ADDR, d);
            cmp_v(14'(d), 14'(stp[k]), "step readback");
            cmp_v(14'(ss_en), 14'(k != 0), "spread enable");
            wr_reg(rsdc_pkg::SS_OFFSET_ADDR, ofv[k]);
            @(posedge clk_in);
            #1 cmp_v(14'(ss_down), 14'(k != 0), "down spread");
        end
        wr_reg(rsdc_pkg::SS_NSSC_ADDR, 8'h06);
        rd_reg(rsdc_pkg::SS_NSSC_ADDR, d);
        cmp_v(14'(d), 14'h6, "quadrant readback");
        wr_reg(rsdc_pkg::FRACTIONAL_LOOP_D_ADDR, 8'h7f);
        @(posedge clk_in);
        #1 cmp_v(14'(ref_div), 14'h7f, "ref div");
        gl_chk = 1'b1;
        for (int p = 0; p < 4; p++) begin
            wr_reg(rsdc_pkg::SWITCH_CFG_ADDR, {7'h0, p[1]});
            pin <= p[0];
            repeat (20) @(posedge clk_in);
            wait_sel(p[1] ^ p[0]);
            cmp_v(14'(sel_aux), 14'(p[1] ^ p[0]), "manual select");
            n_ref = 0;
            cnt_en = 1'b1;
            repeat (60) @(posedge clk_in);
            #1 cnt_en = 1'b0;
            cmp_n(n_ref, (p[1] ^ p[0]) ? 10 : 15);
        end
        gl_chk = 1'b0;
        // Automatic mode only with the crystal/ref input as primary
        wr_reg(rsdc_pkg::SWITCH_CFG_ADDR, 8'h04);
        repeat (30) @(posedge clk_in);
        #1 cmp_v(14'(sel_aux), 14'h0, "auto ignores pin");
        xtal_run <= 1'b0;
        repeat (4) @(posedge clk_in);
        #1 cmp_v(14'(sel_aux), 14'h0, "early switch");
        wait_sel(1'b1);
        cmp_v(14'(sel_aux), 14'h1, "auto to secondary");
        rd_reg(rsdc_pkg::STATUS_ADDR, d);
        cmp_v(14'(d), 14'h3, "status readback");
        @(posedge clk_in);
        xtal_run <= 1'b1;
        wait_sel(1'b0);
        cmp_v(14'(sel_aux), 14'h0, "revert to primary");
        close_out();
    end
endmodule : rsdc_ctrl_bench
`default_nettype wire
